// ---- bench/mbic_button_model.sv ----
// Operator model that closes the momentary button for a set number of cycles
`timescale 1ns/1ps
`default_nettype none
module mbic_button_model
(
  // Clock and request
  input wire logic clk_in,
  input wire logic go_in,
  input wire logic [31:0] len_in,
  // Contact, low when released
  output logic button_out
);
  logic [31:0] left = 32'h0;
  // Count down while the contact is held closed
  always_ff @(posedge clk_in)
  begin
    if (go_in)
      left <= len_in;
    else if (left != 32'h0)
      left <= left - 32'h1;
  end
  assign button_out = (left != 32'h0);
endmodule
`default_nettype wire

// ---- bench/mbic_checker.sv ----
// Port checker for the manual button intensity control
`timescale 1ns/1ps
`default_nettype none
module mbic_checker
  import mbic_pkg::*;
(
  // Clock, reset and inputs
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic [15:0] lux_in,
  input wire logic radio_cmd_in,
  input wire mbic_mode_e radio_mode_in,
  input wire mbic_int_e radio_int_in,
  // Outputs
  input wire mbic_int_e led_int_out,
  input wire logic led_on_out,
  input wire mbic_mode_e mode_out,
  input wire logic manual_out,
  input wire logic dark_out
);
  import mbic_pkg::*;
  // Radio intensity 00 is taken as low
  wire [1:0] exp_int = (radio_int_in == MBIC_INT_OFF) ? 2'b01 : radio_int_in;
  wire lux_lo = lux_in < LUX_DARK;
  wire lux_hi = lux_in >= LUX_DAY;
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (sys_rst_in);
  // Five cycles cover the two sync flops, the flag register and the output register
  property p_dark_set;
    lux_lo [*5] |=> dark_out;
  endproperty
  a_dark_set: assert property (p_dark_set) else $error("dark flag not set");
  property p_dark_clr;
    lux_hi [*5] |=> !dark_out;
  endproperty
  a_dark_clr: assert property (p_dark_clr) else $error("dark flag not cleared");
  property p_dark_hold;
    (!lux_lo && !lux_hi) [*5] |=> $stable(dark_out);
  endproperty
  a_dark_hold: assert property (p_dark_hold) else $error("flag moved in band");
  property p_radio_manual;
    radio_cmd_in |-> ##2 !manual_out;
  endproperty
  a_radio_manual: assert property (p_radio_manual) else $error("manual kept");
  property p_radio_mode;
    radio_cmd_in && radio_mode_in != 2'b11 |-> ##2 mode_out == $past(radio_mode_in, 2);
  endproperty
  a_radio_mode: assert property (p_radio_mode) else $error("mode not taken");
  property p_always;
    radio_cmd_in && radio_mode_in == MBIC_MODE_ALWAYS
      |-> ##2 led_on_out && led_int_out == $past(exp_int, 2);
  endproperty
  a_always: assert property (p_always) else $error("level not taken");
  property p_off_int;
    !led_on_out |-> led_int_out == MBIC_INT_OFF;
  endproperty
  a_off_int: assert property (p_off_int) else $error("level while off");
  property p_dusk;
    (mode_out == MBIC_MODE_DUSK && !manual_out && $stable(dark_out)) [*3]
      |-> led_on_out == dark_out;
  endproperty
  a_dusk: assert property (p_dusk) else $error("light not following sensor");
  property p_manual;
    $rose(manual_out) |-> ##[0:3] (mode_out == MBIC_MODE_DUSK && led_int_out == MBIC_INT_LOW);
  endproperty
  a_manual: assert property (p_manual) else $error("bad manual start");
  // Main scenarios
  c_dusk: cover property (radio_cmd_in && radio_mode_in == MBIC_MODE_DUSK);
  c_dawn: cover property (dark_out ##1 !dark_out);
  c_high: cover property (led_on_out && led_int_out == MBIC_INT_HIGH);
endmodule
bind mbic_top mbic_checker u_chk (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .lux_in(lux_in),
  .radio_cmd_in(radio_cmd_in), .radio_mode_in(radio_mode_in), .radio_int_in(radio_int_in),
  .led_int_out(led_int_out), .led_on_out(led_on_out), .mode_out(mode_out),
  .manual_out(manual_out), .dark_out(dark_out));
`default_nettype wire

// ---- bench/mbic_test.sv ----
// Self-checking testbench for the manual button intensity control
`timescale 1ns/1ps
`default_nettype none
module mbic_test;
  import mbic_pkg::*;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [15:0] lux_in = 16'h01f4;
  logic radio_cmd_in = 1'b0;
  mbic_mode_e radio_mode_in = MBIC_MODE_STANDBY;
  mbic_int_e radio_int_in = MBIC_INT_LOW;
  logic radio_tmo_en_in = 1'b0;
  logic [5:0] radio_tmo_min_in = 6'h01;
  logic go = 1'b0;
  logic [31:0] len = 32'h0;
  wire button;
  mbic_int_e led_int_out;
  logic led_on_out;
  mbic_mode_e mode_out;
  logic manual_out;
  logic dark_out;
  int n_fail = 0;
  int n_tests = 0;
  logic [15:0] lv [4] = '{16'h0063, 16'h0095, 16'h0096, 16'h0064};
  logic [1:0] ev [4] = '{2'b11, 2'b11, 2'b00, 2'b00};
  mbic_button_model u_btn (.clk_in(clk_in), .go_in(go), .len_in(len), .button_out(button));
  // Shortened timing: settle 200, hold 1000, day window 5000, minute 100 cycles
  mbic_top #(.DEB_CYCLES(200), .HOLD_CYCLES(1000), .DAY_CYCLES(5000), .MIN_CYCLES(100))
    DUT (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .button_in(button), .lux_in(lux_in),
    .radio_cmd_in(radio_cmd_in), .radio_mode_in(radio_mode_in), .radio_int_in(radio_int_in),
    .radio_tmo_en_in(radio_tmo_en_in), .radio_tmo_min_in(radio_tmo_min_in),
    .led_int_out(led_int_out), .led_on_out(led_on_out), .mode_out(mode_out),
    .manual_out(manual_out), .dark_out(dark_out));
  initial forever #5 clk_in = ~clk_in;
  task automatic chk(input logic [1:0] got, input logic [1:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One radio command; results settle two edges after it is taken
  task automatic radio(input mbic_mode_e m, input mbic_int_e i);
    @(posedge clk_in);
    radio_cmd_in <= 1'b1;
    radio_mode_in <= m;
    radio_int_in <= i;
    @(posedge clk_in);
    radio_cmd_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    #1;
  endtask
  // Sensor value is held long enough to pass the synchroniser
  task automatic lux(input logic [15:0] v);
    @(posedge clk_in);
    lux_in <= v;
    repeat (8) @(posedge clk_in);
    #1;
  endtask
  // Operator press of n cycles, then a release long enough to settle
  task automatic push(input int n);
    @(posedge clk_in);
    go <= 1'b1;
    len <= n;
    @(posedge clk_in);
    go <= 1'b0;
    repeat (n + 300) @(posedge clk_in);
    #1;
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Watchdog well beyond the roughly eight thousand cycles the tests need
  initial
  begin
    repeat (20000) @(posedge clk_in);
    n_fail++;
    test_done();
  end
  initial
  begin
    @(posedge clk_in);
    #1;
    chk({led_on_out, manual_out}, 2'b00);
    chk(mode_out, 2'b00);
    @(posedge clk_in);
    sys_rst_in <= 1'b0;
    radio_tmo_en_in <= 1'b1;
    radio_tmo_min_in <= 6'h3f;
    $display("test reset done");
    for (int k = 0; k < 4; k++)
    begin
      radio(MBIC_MODE_ALWAYS, mbic_int_e'(k[1:0]));
      chk(led_int_out, (k == 0) ? 2'b01 : k[1:0]);
      chk({led_on_out, manual_out}, 2'b10);
    end
    $display("test radio levels done");
    // A bounce far shorter than the settle time must not step
    push(100);
    chk(led_int_out, 2'b11);
    chk(manual_out, 2'b00);
    $display("test bounce done");
    radio(MBIC_MODE_DUSK, MBIC_INT_MED);
    chk(mode_out, 2'b10);
    chk({dark_out, led_on_out}, 2'b00);
    for (int k = 0; k < 4; k++)
    begin
      lux(lv[k]);
      chk({dark_out, led_on_out}, ev[k]);
      chk(led_int_out, ev[k] & 2'b10);
    end
    $display("test sensor done");
    radio(MBIC_MODE_STANDBY, MBIC_INT_HIGH);
    chk(mode_out, 2'b00);
    chk(led_int_out, 2'b00);
    chk({led_on_out, manual_out}, 2'b00);
    $display("test standby done");
    // Mid-run reset leaves the light idle; a short press must not activate
    @(posedge clk_in);
    sys_rst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    lux(16'h01f4);
    chk({led_on_out, manual_out}, 2'b00);
    push(300);
    chk({led_on_out, manual_out}, 2'b00);
    $display("test short press done");
    // Long hold in daylight: low intensity, dusk mode, kept lit by the window
    push(1500);
    chk({led_on_out, manual_out}, 2'b11);
    chk(led_int_out, 2'b01);
    chk(mode_out, 2'b10);
    push(300);
    chk(led_int_out, 2'b10);
    push(300);
    chk(led_int_out, 2'b11);
    push(300);
    chk(led_int_out, 2'b01);
    $display("test manual steps done");
    // Window runs out in daylight, then darkness brings the light back
    repeat (3000) @(posedge clk_in);
    #1;
    chk({dark_out, led_on_out}, 2'b00);
    chk(led_int_out, 2'b00);
    lux(16'h0063);
    chk({dark_out, led_on_out}, 2'b11);
    chk(led_int_out, 2'b01);
    $display("test daylight window done");
    // Radio takes over; a zero timeout is clamped to one minute
    @(posedge clk_in);
    radio_tmo_min_in <= 6'h00;
    radio(MBIC_MODE_ALWAYS, MBIC_INT_HIGH);
    chk({led_on_out, manual_out}, 2'b10);
    repeat (90) @(posedge clk_in);
    #1;
    chk(led_int_out, 2'b11);
    repeat (20) @(posedge clk_in);
    #1;
    chk(led_int_out, 2'b01);
    $display("test timeout done");
    test_done();
  end
endmodule
`default_nettype wire

// ---- common/mbic_btn_if.sv ----
// Interface carrying the debounced button events to the controller
`timescale 1ns/1ps
`default_nettype none
interface mbic_btn_if;
  logic press;
  logic long_hold;
  logic level;
  modport src (output press, output long_hold, output level);
  modport dst (input press, input long_hold, input level);
endinterface
`default_nettype wire

// ---- common/mbic_pkg.sv ----
// Package with constants and types for the manual button intensity control
package mbic_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  // Long hold needed to activate, in seconds
  localparam int unsigned HOLD_S = 3;
  localparam longint unsigned HOLD_CYC = longint'(HOLD_S) * CLK_HZ;
  // Daylight keep-on interval, in seconds
  localparam int unsigned DAY_ON_S = 30;
  localparam longint unsigned DAY_ON_CYC = longint'(DAY_ON_S) * CLK_HZ;
  // Debounce settle time, in milliseconds
  localparam int unsigned DEB_MS = 20;
  localparam int unsigned DEB_CYC = (DEB_MS * (CLK_HZ / 1000));
  // One minute tick for the intensity timeout
  localparam int unsigned MIN_S = 60;
  localparam longint unsigned MIN_CYC = longint'(MIN_S) * CLK_HZ;
  // Timeout range in minutes
  localparam logic [5:0] TMO_MIN = 6'h01;
  localparam logic [5:0] TMO_MAX = 6'h3c;
  // Ambient light thresholds in lux
  localparam logic [15:0] LUX_DARK = 16'h0064;
  localparam logic [15:0] LUX_DAY = 16'h0096;
  // Intensity encoding
  typedef enum logic [1:0] {
    MBIC_INT_OFF = 2'b00,
    MBIC_INT_LOW = 2'b01,
    MBIC_INT_MED = 2'b10,
    MBIC_INT_HIGH = 2'b11
  } mbic_int_e;
  // Operating mode encoding
  typedef enum logic [1:0] {
    MBIC_MODE_STANDBY = 2'b00,
    MBIC_MODE_ALWAYS = 2'b01,
    MBIC_MODE_DUSK = 2'b10
  } mbic_mode_e;
  // Reset values
  localparam logic [1:0] RST_INT = 2'b01;
  localparam logic [1:0] RST_MODE = 2'b00;
endpackage

// ---- core/mbic_debounce.sv ----
// Button synchroniser, debouncer and long-hold detector
`timescale 1ns/1ps
`default_nettype none
module mbic_debounce
  import mbic_pkg::*;
#(
  // Settle and hold times in clock cycles
  parameter int unsigned DEB_CYCLES = DEB_CYC,
  parameter longint unsigned HOLD_CYCLES = HOLD_CYC
)
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // Raw button pin
  input wire logic button_in,
  // Events out
  mbic_btn_if.src btn
);
  logic sync_a;
  logic sync_b;
  logic stable;
  logic [21:0] deb_cnt;
  logic [28:0] hold_cnt;
  logic hold_done;
  wire deb_done = (deb_cnt == 22'(DEB_CYCLES - 1));
  wire hold_hit = stable && !hold_done && (hold_cnt == 29'(HOLD_CYCLES - 1));

  // Two flops before the pin is looked at
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
    end
    else
    begin
      sync_a <= button_in;
      sync_b <= sync_a;
    end
  end

  // Accept a new level only after it stays put, so contact bounce is one press
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      deb_cnt <= '0;
      stable <= 1'b0;
    end
    else if (sync_b == stable)
      deb_cnt <= '0;
    else if (deb_done)
    begin
      deb_cnt <= '0;
      stable <= sync_b;
    end
    else
      deb_cnt <= deb_cnt + 22'h000001;
  end

  // Hold timer runs while pressed; fires once per hold
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      hold_cnt <= '0;
      hold_done <= 1'b0;
    end
    else if (!stable)
    begin
      hold_cnt <= '0;
      hold_done <= 1'b0;
    end
    else if (hold_hit)
      hold_done <= 1'b1;
    else if (!hold_done)
      hold_cnt <= hold_cnt + 29'h00000001;
  end

  // Press counts on the first stable assertion, once
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      btn.press <= 1'b0;
      btn.long_hold <= 1'b0;
    end
    else
    begin
      btn.press <= deb_done && sync_b && !stable;
      btn.long_hold <= hold_hit;
    end
  end

  assign btn.level = stable;
endmodule
`default_nettype wire

// ---- core/mbic_top.sv ----
// Manual push button activation and intensity stepping for a solar light
// Overview of operation
// - When inactive, activate only after the button is held 3 seconds.
// - Long-hold activation starts at low intensity.
// - A press at low intensity steps to medium.
// - A press at medium intensity steps to high.
// - A press at high wraps back to low.
// - Button activation forces dusk to dawn mode.
// - Dusk to dawn mode: on in darkness, off in daylight.
// - Daylight activation keeps light on 30 seconds, then sensor decides.
// - Any new radio command returns control to radio.
// - Expiry of the radio-set timeout drops intensity to low.
// - Dark below 100 lux, daylight at 150 lux, with hysteresis.
// - Timeout accepts 1 to 60 minutes from the radio.
`timescale 1ns/1ps
`default_nettype none
module mbic_top
  import mbic_pkg::*;
#(
  // Timing in clock cycles; the real values take seconds, so a bench may shorten them
  parameter int unsigned DEB_CYCLES = DEB_CYC,
  parameter longint unsigned HOLD_CYCLES = HOLD_CYC,
  parameter longint unsigned DAY_CYCLES = DAY_ON_CYC,
  parameter longint unsigned MIN_CYCLES = MIN_CYC
)
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // Button and sensor pins
  input wire logic button_in,
  input wire logic [15:0] lux_in,
  // Radio command path (same clock domain)
  input wire logic radio_cmd_in,
  input wire mbic_mode_e radio_mode_in,
  input wire mbic_int_e radio_int_in,
  input wire logic radio_tmo_en_in,
  input wire logic [5:0] radio_tmo_min_in,
  // Light outputs
  output mbic_int_e led_int_out,
  output logic led_on_out,
  output mbic_mode_e mode_out,
  output logic manual_out,
  output logic dark_out
);
  typedef enum logic [1:0] {
    MBIC_ST_IDLE = 2'b00,
    MBIC_ST_MANUAL = 2'b01,
    MBIC_ST_RADIO = 2'b10
  } mbic_st_e;

  mbic_btn_if btn_if ();

  mbic_st_e state;
  mbic_st_e next_state;
  mbic_int_e level;
  mbic_int_e next_level;
  mbic_mode_e mode;
  mbic_mode_e next_mode;
  logic [15:0] lux_a;
  logic [15:0] lux_b;
  logic dark;
  logic [31:0] day_cnt;
  logic [32:0] min_cnt;
  logic [5:0] tmo_min;
  logic [5:0] tmo_cnt;
  logic tmo_en;

  mbic_debounce #(
    .DEB_CYCLES(DEB_CYCLES),
    .HOLD_CYCLES(HOLD_CYCLES)
  ) u_deb (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .button_in(button_in),
    .btn(btn_if.src)
  );

  // Step function shared by the press path
  function automatic mbic_int_e step_int(input mbic_int_e cur);
    case (cur)
      MBIC_INT_LOW: step_int = MBIC_INT_MED;
      MBIC_INT_MED: step_int = MBIC_INT_HIGH;
      MBIC_INT_HIGH: step_int = MBIC_INT_LOW;
      default: step_int = MBIC_INT_LOW;
    endcase
  endfunction

  // Clamp a requested timeout into its legal range
  function automatic logic [5:0] clamp_tmo(input logic [5:0] v);
    if (v < TMO_MIN)
      clamp_tmo = TMO_MIN;
    else if (v > TMO_MAX)
      clamp_tmo = TMO_MAX;
    else
      clamp_tmo = v;
  endfunction

  wire active = (state != MBIC_ST_IDLE);
  wire activate = btn_if.long_hold && !active;
  wire step = btn_if.press && active && !btn_if.long_hold;
  wire min_tick = (min_cnt == 33'(MIN_CYCLES - 1));
  wire tmo_fire = tmo_en && min_tick && (tmo_cnt == tmo_min - 6'h01) && (level != MBIC_INT_LOW);
  wire day_hold = (day_cnt != 32'h00000000);
  wire light_want = (mode == MBIC_MODE_ALWAYS) || ((mode == MBIC_MODE_DUSK) && (dark || day_hold));

  // Sensor pins pass two flops before any compare
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      // Daylight value, so that no false darkness follows reset
      lux_a <= LUX_DAY;
      lux_b <= LUX_DAY;
    end
    else
    begin
      lux_a <= lux_in;
      lux_b <= lux_a;
    end
  end

  // Hysteresis keeps the light from chattering near dusk
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      dark <= 1'b0;
    else if (lux_b < LUX_DARK)
      dark <= 1'b1;
    else if (lux_b >= LUX_DAY)
      dark <= 1'b0;
  end

  // Control owner and intensity selection
  always_comb
  begin
    next_state = state;
    next_level = level;
    next_mode = mode;
    if (radio_cmd_in)
    begin
      next_state = MBIC_ST_RADIO;
      next_mode = radio_mode_in;
      next_level = (radio_int_in == MBIC_INT_OFF) ? MBIC_INT_LOW : radio_int_in;
    end
    else if (activate)
    begin
      next_state = MBIC_ST_MANUAL;
      next_level = MBIC_INT_LOW;
      next_mode = MBIC_MODE_DUSK;
    end
    else if (step)
      next_level = step_int(level);
    else if (tmo_fire)
      next_level = MBIC_INT_LOW;
  end

  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      state <= MBIC_ST_IDLE;
      level <= mbic_int_e'(RST_INT);
      mode <= mbic_mode_e'(RST_MODE);
    end
    else
    begin
      state <= next_state;
      level <= next_level;
      mode <= next_mode;
    end
  end

  // Daylight keep-on window after a manual activation
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      day_cnt <= '0;
    else if (radio_cmd_in)
      day_cnt <= '0;
    else if (activate && !dark)
      day_cnt <= 32'(DAY_CYCLES);
    else if (day_hold)
      day_cnt <= day_cnt - 32'h00000001;
  end

  // Timeout settings latched from each radio command
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      tmo_en <= 1'b0;
      tmo_min <= TMO_MIN;
    end
    else if (radio_cmd_in)
    begin
      tmo_en <= radio_tmo_en_in;
      tmo_min <= clamp_tmo(radio_tmo_min_in);
    end
  end

  // Minute prescaler and minute counter; restart on any intensity change
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      min_cnt <= '0;
      tmo_cnt <= '0;
    end
    else if (next_level != level || radio_cmd_in || level == MBIC_INT_LOW)
    begin
      min_cnt <= '0;
      tmo_cnt <= '0;
    end
    else if (min_tick)
    begin
      min_cnt <= '0;
      tmo_cnt <= tmo_cnt + 6'h01;
    end
    else
      min_cnt <= min_cnt + 33'h000000001;
  end

  // Registered outputs
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      led_int_out <= MBIC_INT_OFF;
      led_on_out <= 1'b0;
      mode_out <= mbic_mode_e'(RST_MODE);
      manual_out <= 1'b0;
      dark_out <= 1'b0;
    end
    else
    begin
      led_on_out <= active && light_want;
      led_int_out <= (active && light_want) ? level : MBIC_INT_OFF;
      mode_out <= mode;
      manual_out <= (state == MBIC_ST_MANUAL);
      dark_out <= dark;
    end
  end
endmodule
`default_nettype wire
